// ==== bbsc_pkg.sv ====
// Purpose: constants and types shared by the converter 5/6 slot sequencing block
// Assumes: 16-bit registers reached by a simple synchronous register port
// Notes: mask-programmed defaults are parameters of this package
package bbsc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] BBSC_ADDR_CONV5_CTRL = 8'hC0;
  localparam logic [7:0] BBSC_ADDR_CONV5_TMO = 8'hC1;
  localparam logic [7:0] BBSC_ADDR_CONV6_CTRL = 8'hC3;
  localparam logic [7:0] BBSC_ADDR_CONV6_TMO = 8'hC4;

  // ==========================================================
  // field positions
  localparam int BBSC_FB_LSB = 0;
  localparam int BBSC_RMPL_BIT = 3;
  localparam int BBSC_RMPH_BIT = 4;
  localparam int BBSC_ACT_LSB = 14;
  localparam int BBSC_EN_LSB = 10;
  localparam int BBSC_SD_LSB = 6;
  localparam int BBSC_CAP_LSB = 14;
  localparam int BBSC_FLT_BIT = 10;
  localparam int BBSC_VSEL_LSB = 0;

  // ==========================================================
  // writable bits and mask-programmed defaults
  localparam logic [15:0] BBSC_CONV5_CTRL_MASK = 16'h001B;
  localparam logic [15:0] BBSC_TMO_MASK = 16'hFFC0;
  localparam logic [15:0] BBSC_CONV6_CTRL_MASK = 16'hC47F;
  localparam logic [15:0] BBSC_CONV5_CTRL_RST = 16'h0008;
  localparam logic [15:0] BBSC_CONV5_TMO_RST = 16'h0000;
  localparam logic [15:0] BBSC_CONV6_CTRL_RST = 16'h0000;
  localparam logic [15:0] BBSC_CONV6_TMO_RST = 16'h0000;

  // ==========================================================
  // codes
  localparam logic [1:0] BBSC_FB_EXT_PIN = 2'h0;
  localparam logic [1:0] BBSC_FB_SINK_A = 2'h1;
  localparam logic [1:0] BBSC_FB_SINK_B = 2'h2;
  localparam logic [1:0] BBSC_FB_BUS_DIV = 2'h3;
  localparam logic [1:0] BBSC_RAMP_LOW_V = 2'h3;
  localparam logic [1:0] BBSC_ACT_IGNORE = 2'h0;
  localparam logic [1:0] BBSC_ACT_CONV = 2'h1;
  localparam logic [1:0] BBSC_CAP_UNUSED = 2'h2;
  localparam logic [3:0] BBSC_SLOT_NONE = 4'h0;
  localparam logic [3:0] BBSC_SLOT_LAST = 4'hE;
  localparam logic [3:0] BBSC_SLOT_EDGE = 4'hF;
  localparam logic [6:0] BBSC_VSEL_MAX = 7'h66;

  // ==========================================================
  // timing
  localparam int BBSC_CLK_MHZ = 40;
  localparam int BBSC_SLOT_US = 2;
  localparam int BBSC_SLOT_CYC = BBSC_SLOT_US * BBSC_CLK_MHZ;

  typedef enum logic [1:0] {
    BBSC_ST_OFF = 2'b00,
    BBSC_ST_UP = 2'b01,
    BBSC_ST_ACTIVE = 2'b10,
    BBSC_ST_DOWN = 2'b11
  } bbsc_state_t;

  typedef struct packed {
    logic [1:0] action;
    logic [3:0] en_slot;
    logic [3:0] sd_slot;
  } bbsc_slot_cfg_t;
endpackage : bbsc_pkg

// ==== bbsc_conv_slot.sv ====
// Purpose: enable and fault handling for one converter in the slot sequence
// Assumes: slot strobes come from the shared sequencer
// Notes: one instance per converter
`timescale 1ns/10ps
module bbsc_conv_slot
  import bbsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire bbsc_slot_cfg_t cfg_in,
  input wire logic up_tick_in,
  input wire logic down_tick_in,
  input wire logic [3:0] slot_in,
  input wire logic enter_active_in,
  input wire logic enter_off_in,
  input wire logic fault_in,
  output logic enable_out,
  output logic irq_out,
  output logic sys_sd_out
);
  logic en_r;
  logic irq_r;
  logic sd_r;
  wire logic up_hit = up_tick_in && cfg_in.en_slot == slot_in &&
                      cfg_in.en_slot != BBSC_SLOT_NONE && cfg_in.en_slot <= BBSC_SLOT_LAST;
  wire logic act_hit = enter_active_in && cfg_in.en_slot == BBSC_SLOT_EDGE;
  wire logic sd_mid = cfg_in.sd_slot != BBSC_SLOT_NONE && cfg_in.sd_slot <= BBSC_SLOT_LAST;
  wire logic dn_hit = (down_tick_in && sd_mid && cfg_in.sd_slot == slot_in) ||
                      (enter_off_in && !sd_mid);
  wire logic conv_kill = fault_in && cfg_in.action == BBSC_ACT_CONV;
  wire logic sys_kill = fault_in && cfg_in.action[1];

  // shutdown wins over start-up when both land together
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      en_r <= 1'b0;
      irq_r <= 1'b0;
      sd_r <= 1'b0;
    end else if (ce_in) begin
      if (dn_hit || conv_kill) begin
        en_r <= 1'b0;
      end else if (up_hit || act_hit) begin
        en_r <= 1'b1;
      end
      irq_r <= fault_in;
      sd_r <= sys_kill;
    end
  end
  assign enable_out = en_r;
  assign irq_out = irq_r;
  assign sys_sd_out = sd_r;
endmodule : bbsc_conv_slot

// ==== bbsc_top.sv ====
// Purpose: converter 5/6 feedback, fault action and slot sequencing control
// Assumes: register port and state inputs synchronous to CLK_IN
// Notes: analogue regulation lies outside; settings are driven out as codes
// What this block does
// - feedback codes 01/10/11 pick sinks or divider
// - code 00 uses external divider pin
// - divider feedback forces low-voltage ramp code
// - conv5 fault: interrupt plus programmed action
// - conv5 start slot: never, 1-14, active
// - conv5 shutdown slot 1-14, else at off
// - conv6 cap select, code 10 unused
// - conv6 bit10: 0 discharge, 1 float
// - conv6 voltage code capped at 3.4V
// - conv6 fault: interrupt plus programmed action
// - conv6 start slot same coding as conv5
// - conv6 shutdown slot 1-14, else at off
// - state machine reset restores mask defaults
`timescale 1ns/10ps
module bbsc_top
  import bbsc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CE_IN,
  input wire logic PSM_RESET_IN,
  input wire logic START_UP_IN,
  input wire logic SHUT_DOWN_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic CONV5_FAULT_IN,
  input wire logic CONV6_FAULT_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic [1:0] SEQ_STATE_OUT,
  output logic [3:0] SLOT_OUT,
  output logic CONV5_ENABLE_OUT,
  output logic CONV6_ENABLE_OUT,
  output logic [1:0] CONV5_FEEDBACK_SELECT_OUT,
  output logic CONV5_FB_PIN_OUT,
  output logic CONV5_FB_SINK_A_OUT,
  output logic CONV5_FB_SINK_B_OUT,
  output logic CONV5_FB_BUS_DIV_OUT,
  output logic [1:0] CONV5_RAMP_OUT,
  output logic [1:0] CONV6_CAP_SELECT_OUT,
  output logic CONV6_DISCHARGE_OUT,
  output logic [6:0] CONV6_VOLTAGE_CODE_OUT,
  output logic CONV5_IRQ_OUT,
  output logic CONV6_IRQ_OUT,
  output logic SYS_SHUTDOWN_OUT
);
  // ==========================================================
  // registers
  logic [15:0] c5_ctrl_r;
  logic [15:0] c5_tmo_r;
  logic [15:0] c6_ctrl_r;
  logic [15:0] c6_tmo_r;
  logic [15:0] rdata_r;
  wire logic defaults = SYS_RST_IN || PSM_RESET_IN;
  wire logic wr_c5c = REG_WR_IN && REG_ADDR_IN == BBSC_ADDR_CONV5_CTRL;
  wire logic wr_c5t = REG_WR_IN && REG_ADDR_IN == BBSC_ADDR_CONV5_TMO;
  wire logic wr_c6c = REG_WR_IN && REG_ADDR_IN == BBSC_ADDR_CONV6_CTRL;
  wire logic wr_c6t = REG_WR_IN && REG_ADDR_IN == BBSC_ADDR_CONV6_TMO;
  wire logic [6:0] vsel_wr = REG_WDATA_IN[BBSC_VSEL_LSB +: 7];
  wire logic [6:0] vsel_ok = (vsel_wr > BBSC_VSEL_MAX) ? BBSC_VSEL_MAX : vsel_wr;
  wire logic [1:0] cap_wr = REG_WDATA_IN[BBSC_CAP_LSB +: 2];
  wire logic [1:0] cap_ok = (cap_wr == BBSC_CAP_UNUSED) ? c6_ctrl_r[BBSC_CAP_LSB +: 2] : cap_wr;
  wire logic [15:0] c6_wr = {cap_ok, REG_WDATA_IN[13:7], vsel_ok} & BBSC_CONV6_CTRL_MASK;

  always_ff @(posedge CLK_IN) begin
    if (defaults) begin
      c5_ctrl_r <= BBSC_CONV5_CTRL_RST;
      c5_tmo_r <= BBSC_CONV5_TMO_RST;
      c6_ctrl_r <= BBSC_CONV6_CTRL_RST;
      c6_tmo_r <= BBSC_CONV6_TMO_RST;
    end else if (CE_IN) begin
      if (wr_c5c) c5_ctrl_r <= REG_WDATA_IN & BBSC_CONV5_CTRL_MASK;
      if (wr_c5t) c5_tmo_r <= REG_WDATA_IN & BBSC_TMO_MASK;
      // unused cap code keeps old value; voltage clamped to top code
      if (wr_c6c) c6_ctrl_r <= c6_wr;
      if (wr_c6t) c6_tmo_r <= REG_WDATA_IN & BBSC_TMO_MASK;
    end
  end

  // ==========================================================
  // read back, registered one cycle after the address
  wire logic [15:0] rd_mux =
    (REG_ADDR_IN == BBSC_ADDR_CONV5_CTRL) ? c5_ctrl_r :
    (REG_ADDR_IN == BBSC_ADDR_CONV5_TMO) ? c5_tmo_r :
    (REG_ADDR_IN == BBSC_ADDR_CONV6_CTRL) ? c6_ctrl_r :
    (REG_ADDR_IN == BBSC_ADDR_CONV6_TMO) ? c6_tmo_r : 16'h0000;
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) rdata_r <= 16'h0000;
    else if (CE_IN) rdata_r <= rd_mux;
  end

  // ==========================================================
  // slot sequencer
  bbsc_state_t st_r;
  bbsc_state_t st_nxt;
  logic [3:0] slot_r;
  logic [7:0] tick_cnt_r;
  logic enter_act_r;
  logic enter_off_r;
  wire logic sys_sd5;
  wire logic sys_sd6;
  wire logic sys_sd = sys_sd5 || sys_sd6;
  wire logic tick = tick_cnt_r == 8'(BBSC_SLOT_CYC - 1);
  wire logic seq_run = st_r == BBSC_ST_UP || st_r == BBSC_ST_DOWN;
  wire logic last_slot = tick && slot_r == BBSC_SLOT_LAST;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      BBSC_ST_OFF: if (START_UP_IN && !sys_sd) st_nxt = BBSC_ST_UP;
      BBSC_ST_UP: if (sys_sd) st_nxt = BBSC_ST_DOWN;
        else if (last_slot) st_nxt = BBSC_ST_ACTIVE;
      BBSC_ST_ACTIVE: if (SHUT_DOWN_IN || sys_sd) st_nxt = BBSC_ST_DOWN;
      BBSC_ST_DOWN: if (last_slot) st_nxt = BBSC_ST_OFF;
      default: st_nxt = BBSC_ST_OFF;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (defaults) begin
      st_r <= BBSC_ST_OFF;
      slot_r <= 4'h1;
      tick_cnt_r <= 8'h00;
      enter_act_r <= 1'b0;
      enter_off_r <= 1'b0;
    end else if (CE_IN) begin
      st_r <= st_nxt;
      enter_act_r <= st_nxt == BBSC_ST_ACTIVE && st_r != BBSC_ST_ACTIVE;
      enter_off_r <= st_nxt == BBSC_ST_OFF && st_r == BBSC_ST_DOWN;
      if (!seq_run || st_nxt != st_r) begin
        tick_cnt_r <= 8'h00;
        slot_r <= 4'h1;
      end else if (tick) begin
        tick_cnt_r <= 8'h00;
        slot_r <= slot_r + 4'h1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // per-converter slot handling
  wire bbsc_slot_cfg_t cfg5 = {c5_tmo_r[BBSC_ACT_LSB +: 2], c5_tmo_r[BBSC_EN_LSB +: 4],
                               c5_tmo_r[BBSC_SD_LSB +: 4]};
  wire bbsc_slot_cfg_t cfg6 = {c6_tmo_r[BBSC_ACT_LSB +: 2], c6_tmo_r[BBSC_EN_LSB +: 4],
                               c6_tmo_r[BBSC_SD_LSB +: 4]};
  wire logic up_tick = st_r == BBSC_ST_UP && tick;
  wire logic dn_tick = st_r == BBSC_ST_DOWN && tick;
  wire logic conv_rst = defaults;

  bbsc_conv_slot u_conv5 (
    .clk_in(CLK_IN),
    .rst_in(conv_rst),
    .ce_in(CE_IN),
    .cfg_in(cfg5),
    .up_tick_in(up_tick),
    .down_tick_in(dn_tick),
    .slot_in(slot_r),
    .enter_active_in(enter_act_r),
    .enter_off_in(enter_off_r),
    .fault_in(CONV5_FAULT_IN),
    .enable_out(CONV5_ENABLE_OUT),
    .irq_out(CONV5_IRQ_OUT),
    .sys_sd_out(sys_sd5)
  );
  bbsc_conv_slot u_conv6 (
    .clk_in(CLK_IN),
    .rst_in(conv_rst),
    .ce_in(CE_IN),
    .cfg_in(cfg6),
    .up_tick_in(up_tick),
    .down_tick_in(dn_tick),
    .slot_in(slot_r),
    .enter_active_in(enter_act_r),
    .enter_off_in(enter_off_r),
    .fault_in(CONV6_FAULT_IN),
    .enable_out(CONV6_ENABLE_OUT),
    .irq_out(CONV6_IRQ_OUT),
    .sys_sd_out(sys_sd6)
  );

  // ==========================================================
  // analogue settings, registered
  wire logic [1:0] fb = c5_ctrl_r[BBSC_FB_LSB +: 2];
  wire logic [1:0] ramp_bits = {c5_ctrl_r[BBSC_RMPH_BIT], c5_ctrl_r[BBSC_RMPL_BIT]};
  logic [1:0] fb_r;
  logic [3:0] fb_onehot_r;
  logic [1:0] ramp_r;
  logic [1:0] cap_r;
  logic dis_r;
  logic [6:0] vsel_r;
  logic sys_sd_r;
  always_ff @(posedge CLK_IN) begin
    if (defaults) begin
      fb_r <= BBSC_FB_EXT_PIN;
      fb_onehot_r <= 4'h1;
      ramp_r <= 2'h1;
      cap_r <= 2'h0;
      dis_r <= 1'b0;
      vsel_r <= 7'h00;
      sys_sd_r <= 1'b0;
    end else if (CE_IN) begin
      fb_r <= fb;
      fb_onehot_r <= {fb == BBSC_FB_BUS_DIV, fb == BBSC_FB_SINK_B,
                      fb == BBSC_FB_SINK_A, fb == BBSC_FB_EXT_PIN};
      ramp_r <= (fb == BBSC_FB_BUS_DIV) ? BBSC_RAMP_LOW_V : ramp_bits;
      cap_r <= c6_ctrl_r[BBSC_CAP_LSB +: 2];
      // discharge only while disabled and float bit clear
      dis_r <= !c6_ctrl_r[BBSC_FLT_BIT] && !CONV6_ENABLE_OUT;
      vsel_r <= c6_ctrl_r[BBSC_VSEL_LSB +: 7];
      sys_sd_r <= sys_sd;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  assign SEQ_STATE_OUT = st_r;
  assign SLOT_OUT = slot_r;
  assign CONV5_FEEDBACK_SELECT_OUT = fb_r;
  assign CONV5_FB_PIN_OUT = fb_onehot_r[0];
  assign CONV5_FB_SINK_A_OUT = fb_onehot_r[1];
  assign CONV5_FB_SINK_B_OUT = fb_onehot_r[2];
  assign CONV5_FB_BUS_DIV_OUT = fb_onehot_r[3];
  assign CONV5_RAMP_OUT = ramp_r;
  assign CONV6_CAP_SELECT_OUT = cap_r;
  assign CONV6_DISCHARGE_OUT = dis_r;
  assign CONV6_VOLTAGE_CODE_OUT = vsel_r;
  assign SYS_SHUTDOWN_OUT = sys_sd_r;
endmodule : bbsc_top

// ==== bbsc_assertions.sv ====
// Purpose: port-level checks for bbsc_top
// Assumes: one clock, sync reset high
// Notes: bound from the bench top file
`timescale 1ns/10ps
module bbsc_assertions
  import bbsc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CE_IN,
  input wire logic PSM_RESET_IN,
  input wire logic CONV5_FAULT_IN,
  input wire logic CONV6_FAULT_IN,
  input wire logic [1:0] SEQ_STATE_OUT,
  input wire logic [3:0] SLOT_OUT,
  input wire logic CONV5_ENABLE_OUT,
  input wire logic [1:0] CONV5_FEEDBACK_SELECT_OUT,
  input wire logic CONV5_FB_PIN_OUT,
  input wire logic CONV5_FB_SINK_A_OUT,
  input wire logic CONV5_FB_BUS_DIV_OUT,
  input wire logic [1:0] CONV5_RAMP_OUT,
  input wire logic [1:0] CONV6_CAP_SELECT_OUT,
  input wire logic [6:0] CONV6_VOLTAGE_CODE_OUT,
  input wire logic CONV5_IRQ_OUT,
  input wire logic CONV6_IRQ_OUT,
  input wire logic SYS_SHUTDOWN_OUT
);
  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_fb_sink_a: assert property (
    CONV5_FB_SINK_A_OUT == (CONV5_FEEDBACK_SELECT_OUT == 2'h1))
    else $error("sink a select mismatch");
  a_fb_ext_pin: assert property (
    CONV5_FB_PIN_OUT == (CONV5_FEEDBACK_SELECT_OUT == 2'h0))
    else $error("pin select mismatch");
  a_div_ramp: assert property (CONV5_FB_BUS_DIV_OUT |-> CONV5_RAMP_OUT == 2'h3)
    else $error("divider without low ramp");
  a_irq5_follow: assert property (
    CE_IN && CONV5_FAULT_IN && !PSM_RESET_IN |=> CONV5_IRQ_OUT)
    else $error("conv5 irq missing");
  a_irq6_follow: assert property (
    CE_IN && CONV6_FAULT_IN && !PSM_RESET_IN |=> CONV6_IRQ_OUT)
    else $error("conv6 irq missing");
  a_cap_unused: assert property (CONV6_CAP_SELECT_OUT != 2'h2)
    else $error("unused cap code");
  a_vsel_max: assert property (CONV6_VOLTAGE_CODE_OUT <= 7'h66)
    else $error("voltage code above max");
  a_slot_range: assert property (SLOT_OUT >= 4'h1 && SLOT_OUT <= 4'hE)
    else $error("slot out of range");
  a_enable_state: assert property ($rose(CONV5_ENABLE_OUT) |-> SEQ_STATE_OUT != 2'h0)
    else $error("conv5 enabled while off");
  a_sys_sd_cause: assert property ($rose(SYS_SHUTDOWN_OUT) |->
    $past(CONV5_FAULT_IN, 2) || $past(CONV6_FAULT_IN, 2))
    else $error("system shutdown without fault");
endmodule : bbsc_assertions

// ==== bbsc_top_tb_top.sv ====
// Purpose: self-checking bench for bbsc_top
// Assumes: slot interval from the package
// Notes: one task per scenario
`timescale 1ns/10ps
module bbsc_top_tb_top;
  import bbsc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psm = 1'b0, up = 1'b0, dn = 1'b0, wr = 1'b0;
  logic f5 = 1'b0, f6 = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000, rd;
  logic [1:0] st, fb, ramp, cap;
  logic [3:0] slot;
  logic [6:0] vc;
  logic e5, e6, pin, sa, sb, dv, dis, i5, i6, sd;
  int fails = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  bbsc_top u_bbsc_top (.CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .PSM_RESET_IN(psm),
    .START_UP_IN(up), .SHUT_DOWN_IN(dn), .REG_WR_IN(wr), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wd), .CONV5_FAULT_IN(f5), .CONV6_FAULT_IN(f6), .REG_RDATA_OUT(rd),
    .SEQ_STATE_OUT(st), .SLOT_OUT(slot), .CONV5_ENABLE_OUT(e5), .CONV6_ENABLE_OUT(e6),
    .CONV5_FEEDBACK_SELECT_OUT(fb), .CONV5_FB_PIN_OUT(pin), .CONV5_FB_SINK_A_OUT(sa),
    .CONV5_FB_SINK_B_OUT(sb), .CONV5_FB_BUS_DIV_OUT(dv), .CONV5_RAMP_OUT(ramp),
    .CONV6_CAP_SELECT_OUT(cap), .CONV6_DISCHARGE_OUT(dis), .CONV6_VOLTAGE_CODE_OUT(vc),
    .CONV5_IRQ_OUT(i5), .CONV6_IRQ_OUT(i6), .SYS_SHUTDOWN_OUT(sd));
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // settings land one edge after the write edge; the task waits two
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1;
    chk("rdata", e, rd);
  endtask : rreg
  // bounded wait so a stuck sequencer fails instead of hanging
  task automatic wait_lvl(ref logic s, input logic v);
    for (int i = 0; i < 3000 && s !== v; i++) begin
      @(posedge clk);
      #1;
    end
    // a timeout shows up here as a mismatch
    chk("level", {15'h0, v}, {15'h0, s});
  endtask : wait_lvl
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rreg(BBSC_ADDR_CONV5_CTRL, 16'h0008);
    rreg(BBSC_ADDR_CONV5_TMO, 16'h0000);
    rreg(BBSC_ADDR_CONV6_CTRL, 16'h0000);
    rreg(BBSC_ADDR_CONV6_TMO, 16'h0000);
    rreg(8'hC2, 16'h0000);
    chk("discharge", 16'h0001, {15'h0, dis});
  endtask : t_reset
  task automatic t_feedback();
    for (int c = 0; c < 4; c++) begin
      wreg(BBSC_ADDR_CONV5_CTRL, 16'(c));
      chk("fb_sel", 16'(c), {14'h0, fb});
      chk("fb_hot", 16'(1 << (3 - c)), {12'h0, pin, sa, sb, dv});
      chk("ramp", (c == 3) ? 16'h0003 : 16'h0000, {14'h0, ramp});
    end
    wreg(BBSC_ADDR_CONV5_CTRL, 16'hFFFF);
    rreg(BBSC_ADDR_CONV5_CTRL, 16'h001B);
  endtask : t_feedback
  task automatic t_conv6();
    wreg(BBSC_ADDR_CONV6_CTRL, 16'h4070);
    chk("cap", 16'h0001, {14'h0, cap});
    chk("vsel", 16'h0066, {9'h0, vc});
    chk("discharge", 16'h0001, {15'h0, dis});
    wreg(BBSC_ADDR_CONV6_CTRL, 16'h8420);
    rreg(BBSC_ADDR_CONV6_CTRL, 16'h4420);
    chk("discharge", 16'h0000, {15'h0, dis});
  endtask : t_conv6
  task automatic t_seq();
    wreg(BBSC_ADDR_CONV5_TMO, 16'h0800);
    wreg(BBSC_ADDR_CONV6_TMO, 16'h3C40);
    @(posedge clk);
    up <= 1'b1;
    wait_lvl(e5, 1'b1);
    @(posedge clk);
    up <= 1'b0;
    #1;
    chk("state", 16'(BBSC_ST_UP), {14'h0, st});
    // slot counter has already stepped past the matching slot
    chk("slot", 16'h0003, {12'h0, slot});
    chk("en6", 16'h0000, {15'h0, e6});
    wait_lvl(e6, 1'b1);
    chk("state", 16'(BBSC_ST_ACTIVE), {14'h0, st});
    @(posedge clk);
    dn <= 1'b1;
    wait_lvl(e6, 1'b0);
    @(posedge clk);
    dn <= 1'b0;
    #1;
    chk("state", 16'(BBSC_ST_DOWN), {14'h0, st});
    chk("en5", 16'h0001, {15'h0, e5});
    wait_lvl(e5, 1'b0);
    chk("state", 16'(BBSC_ST_OFF), {14'h0, st});
  endtask : t_seq
  task automatic t_fault();
    wreg(BBSC_ADDR_CONV5_TMO, 16'h4000);
    wreg(BBSC_ADDR_CONV6_TMO, 16'h8000);
    @(posedge clk);
    f5 <= 1'b1;
    @(posedge clk);
    #1;
    chk("irq5", 16'h0001, {15'h0, i5});
    @(posedge clk);
    f5 <= 1'b0;
    f6 <= 1'b1;
    #1;
    chk("sys_sd", 16'h0000, {15'h0, sd});
    @(posedge clk);
    #1;
    chk("irq6", 16'h0001, {15'h0, i6});
    @(posedge clk);
    f6 <= 1'b0;
    #1;
    chk("sys_sd", 16'h0001, {15'h0, sd});
  endtask : t_fault
  task automatic t_psm();
    wreg(BBSC_ADDR_CONV6_CTRL, 16'h4010);
    @(posedge clk);
    psm <= 1'b1;
    @(posedge clk);
    psm <= 1'b0;
    rreg(BBSC_ADDR_CONV6_CTRL, 16'h0000);
    rreg(BBSC_ADDR_CONV5_TMO, 16'h0000);
    rreg(BBSC_ADDR_CONV5_CTRL, 16'h0008);
    // clock enable low: the write must not land, defaults stay
    @(posedge clk);
    ce <= 1'b0;
    wreg(BBSC_ADDR_CONV6_CTRL, 16'h4011);
    @(posedge clk);
    ce <= 1'b1;
    rreg(BBSC_ADDR_CONV6_CTRL, 16'h0000);
    chk("vsel", 16'h0000, {9'h0, vc});
  endtask : t_psm
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_feedback();
    t_conv6();
    t_seq();
    t_fault();
    t_psm();
    report_and_stop();
  end
  initial begin
    repeat (12000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule : bbsc_top_tb_top
bind bbsc_top bbsc_assertions u_bbsc_assertions (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .CE_IN(CE_IN), .PSM_RESET_IN(PSM_RESET_IN), .CONV5_FAULT_IN(CONV5_FAULT_IN),
  .CONV6_FAULT_IN(CONV6_FAULT_IN), .SEQ_STATE_OUT(SEQ_STATE_OUT), .SLOT_OUT(SLOT_OUT),
  .CONV5_ENABLE_OUT(CONV5_ENABLE_OUT), .CONV5_FEEDBACK_SELECT_OUT(CONV5_FEEDBACK_SELECT_OUT),
  .CONV5_FB_PIN_OUT(CONV5_FB_PIN_OUT), .CONV5_FB_SINK_A_OUT(CONV5_FB_SINK_A_OUT),
  .CONV5_FB_BUS_DIV_OUT(CONV5_FB_BUS_DIV_OUT), .CONV5_RAMP_OUT(CONV5_RAMP_OUT),
  .CONV6_CAP_SELECT_OUT(CONV6_CAP_SELECT_OUT), .CONV6_VOLTAGE_CODE_OUT(CONV6_VOLTAGE_CODE_OUT),
  .CONV5_IRQ_OUT(CONV5_IRQ_OUT), .CONV6_IRQ_OUT(CONV6_IRQ_OUT),
  .SYS_SHUTDOWN_OUT(SYS_SHUTDOWN_OUT));
